// ===== inc/clock_config_params.svh
// Constants for the strap-default configuration loader and its control word
`ifndef CLOCK_CONFIG_PARAMS_SVH
`define CLOCK_CONFIG_PARAMS_SVH

// ----------------------------------------------------------------
// Control word geometry
// ----------------------------------------------------------------
`define CCD_REG_W 28
`define CCD_FRAME_W 32
`define CCD_ADDR_W 4
`define CCD_INPUT_AND_REFERENCE_CONTROL_ADDR 4'h0
`define CCD_CMD_STORE_ADDR 4'hF
`define CCD_INPUT_AND_REFERENCE_CONTROL_RESET 28'h000_0000

// ----------------------------------------------------------------
// Field positions inside the control word
// ----------------------------------------------------------------
`define CCD_REF_BUFFER_TYPE_HI_BIT 0
`define CCD_REF_BUFFER_TYPE_LO_BIT 1
`define CCD_REF_INPUT_CHOICE_LO 2
`define CCD_OSCILLATOR_PATH_SELECT_BIT 4
`define CCD_REF_CONTROL_SOURCE_BIT 5
`define CCD_DETECTOR_PULSE_WIDTH_LO 6
`define CCD_PUMP_POLARITY_BIT 9
`define CCD_PUMP_SOURCE_TEST_BIT 10

// ----------------------------------------------------------------
// Stored variants, loaded into the store at reset
// ----------------------------------------------------------------
`define CCD_VARIANT0_DEFAULT 28'h000_0000
`define CCD_VARIANT1_DEFAULT 28'h000_0000
`define CCD_VARIANT2_DEFAULT 28'h000_0000
`define CCD_VARIANT3_DEFAULT 28'h000_0000
`define CCD_VARIANTS 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCD_SETTLE_CYCLES 2'd3
`define CCD_SYNC_PINS 7
// Pin levels at rest (power-down, frame enable, mode pin high); no false edge after reset
`define CCD_SYNC_IDLE 7'h49

`endif

// ===== inc/clock_config_pkg.sv
// Types shared by the strap-default configuration loader
package clock_config_pkg;

    // ------------------------------------------------------------
    // Reference input buffer kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUF_CMOS,
        BUF_PECL,
        BUF_LVDS
    } buf_type_t;

    // ------------------------------------------------------------
    // Loader sequence
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_SAMPLE,
        ST_FETCH,
        ST_RUN,
        ST_POWER_DOWN
    } load_state_t;

    typedef logic [27:0] cfg_word_t;

endpackage

// ===== src/config_store.sv
// Small store holding the four configuration variants, registered read
`timescale 1ns/1ps
`default_nettype none
`include "clock_config_params.svh"

module config_store (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_rd_en,
    input wire logic [1:0] i_rd_addr,
    output logic [`CCD_REG_W-1:0] o_rd_data,
    input wire logic i_wr_en,
    input wire logic [1:0] i_wr_addr,
    input wire logic [`CCD_REG_W-1:0] i_wr_data
);
    import clock_config_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [`CCD_REG_W-1:0] mem_reg [0:`CCD_VARIANTS-1]; // Variant words

    // Factory image per slot
    function automatic logic [`CCD_REG_W-1:0] default_of(input int idx);
        unique case (idx)
            0: default_of = `CCD_VARIANT0_DEFAULT;
            1: default_of = `CCD_VARIANT1_DEFAULT;
            2: default_of = `CCD_VARIANT2_DEFAULT;
            default: default_of = `CCD_VARIANT3_DEFAULT;
        endcase
    endfunction

    // Reset restores the factory image; a write replaces one slot
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int i = 0; i < `CCD_VARIANTS; i++) begin
                mem_reg[i] <= default_of(i);
            end
        end else if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    // Read data leave through a register, one cycle after the request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_data <= `CCD_INPUT_AND_REFERENCE_CONTROL_RESET;
        end else if (i_rd_en) begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end

endmodule
`default_nettype wire

// ===== src/clock_config_default_mode.sv
// Strap-default configuration loader and first control word of the synchronizer
//
// Notes on behaviour
// - Mode pin low selects strap-default mode
// - Serial pins become four static strap inputs
// - Straps sampled only at power-up or power-down exit
// - Two variant straps pick stored word to load
// - Variant A swaps dividers/phase between output pairs
// - Variant B selects alternate output signalling type
// - Aux strap chooses oscillator or auxiliary mux input
// - Bits 0-1 choose PECL, LVDS or CMOS
// - Bits 2-3 choose none, primary or automatic
// - Bit 4 set selects oscillator, overriding 2-3
// - Bit 5 clear: external pin picks reference
// - Bit 5 set: ignore pin, use bits 2-3
// - Bits 6-7 set detector pulse width
// - Bit 9 sets charge-pump current direction
// - Bit 10 turns on pump source test
`timescale 1ns/1ps
`default_nettype none
`include "clock_config_params.svh"

module clock_config_default_mode (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_strap_default_mode_n,
    input wire logic i_spi_clk_pin,
    input wire logic i_spi_mosi_pin,
    input wire logic i_spi_le_pin,
    input wire logic i_spi_miso_pin,
    output logic o_spi_miso,
    output logic o_spi_miso_oe_n,
    input wire logic i_ref_select,
    input wire logic i_power_down_n,
    output clock_config_pkg::buf_type_t o_ref_buffer_type,
    output logic o_ref_single_ended,
    output logic o_route_primary,
    output logic o_route_secondary,
    output logic o_auto_select,
    output logic o_secondary_buffer_off,
    output logic o_oscillator_path_select,
    output logic [1:0] o_detector_pulse_width,
    output logic o_pump_polarity,
    output logic o_pump_source_test,
    output logic o_swap_output_pairs,
    output logic o_alt_output_type,
    output logic o_aux_mux_select,
    output logic o_default_mode_active,
    output logic o_load_busy
);
    import clock_config_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pin order: 0 mode_n, 1 sclk, 2 mosi, 3 le, 4 miso, 5 ref_sel, 6 pd_n
    logic [`CCD_SYNC_PINS-1:0] pins_raw; // Raw pin vector
    logic [`CCD_SYNC_PINS-1:0] sync1_reg; // First stage, read only by stage two
    logic [`CCD_SYNC_PINS-1:0] sync2_reg; // Usable level
    logic [`CCD_SYNC_PINS-1:0] sync3_reg; // Delayed copy for edges
    localparam logic [`CCD_SYNC_PINS-1:0] sync_idle = `CCD_SYNC_IDLE; // Reset levels

    assign pins_raw = {i_power_down_n, i_ref_select, i_spi_miso_pin, i_spi_le_pin,
                       i_spi_mosi_pin, i_spi_clk_pin, i_strap_default_mode_n};

    // Every pin is asynchronous to the system clock
    generate
        for (genvar g = 0; g < `CCD_SYNC_PINS; g++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    sync1_reg[g] <= sync_idle[g];
                    sync2_reg[g] <= sync_idle[g];
                    sync3_reg[g] <= sync_idle[g];
                end else begin
                    sync1_reg[g] <= pins_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Decoded pin levels and edges
    // ------------------------------------------------------------
    logic strap_default_mode; // Strap-default mode selected
    logic sclk_rise; // Serial clock rising
    logic sclk_fall; // Serial clock falling
    logic le_low; // Frame in progress
    logic le_rise; // Frame ends
    logic le_fall; // Frame starts
    logic pd_active; // Power-down requested
    logic ext_primary; // External pin asks for primary

    assign strap_default_mode = ~sync2_reg[0];
    assign sclk_rise = sync2_reg[1] & ~sync3_reg[1];
    assign sclk_fall = ~sync2_reg[1] & sync3_reg[1];
    assign le_low = ~sync2_reg[3];
    assign le_rise = sync2_reg[3] & ~sync3_reg[3];
    assign le_fall = ~sync2_reg[3] & sync3_reg[3];
    assign pd_active = ~sync2_reg[6];
    assign ext_primary = sync2_reg[5];

    // Serial pins read as straps in default mode, else variant 0
    logic strap_a; // Variant select A level
    logic strap_b; // Variant select B level
    logic strap_aux; // Aux mux select level
    logic [1:0] variant_idx; // Stored word to fetch

    assign strap_a = strap_default_mode & sync2_reg[2];
    assign strap_b = strap_default_mode & sync2_reg[1];
    assign strap_aux = strap_default_mode & sync2_reg[4];
    // Reserved strap (le pin) is assumed grounded by the board
    assign variant_idx = {strap_b, strap_a};

    // ------------------------------------------------------------
    // Loader sequence
    // ------------------------------------------------------------
    load_state_t state_reg; // Current step
    load_state_t state_next; // Next step
    logic [1:0] settle_reg; // Waits for synchronisers after reset
    logic [`CCD_REG_W-1:0] store_rd_data; // Word from the store
    logic rd_en; // Fetch request
    logic sample_now; // Straps captured this cycle

    assign sample_now = (state_reg == ST_SAMPLE);
    assign rd_en = sample_now;

    // Straps only move on at power-up or on leaving power-down
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_SETTLE: begin
                if (settle_reg == `CCD_SETTLE_CYCLES) begin
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                state_next = ST_FETCH;
            end
            ST_FETCH: begin
                state_next = ST_RUN;
            end
            ST_RUN: begin
                if (pd_active) begin
                    state_next = ST_POWER_DOWN;
                end
            end
            ST_POWER_DOWN: begin
                if (!pd_active) begin
                    state_next = ST_SAMPLE;
                end
            end
        endcase
    end

    // Step register and settle counter
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_reg <= ST_SETTLE;
            settle_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_SETTLE) begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    // Strap latches: fixed between samples, pins ignored meanwhile
    logic strap_a_reg; // Captured variant A
    logic strap_b_reg; // Captured variant B
    logic strap_aux_reg; // Captured aux select

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            strap_a_reg <= 1'b0;
            strap_b_reg <= 1'b0;
            strap_aux_reg <= 1'b0;
        end else if (sample_now) begin
            strap_a_reg <= strap_a;
            strap_b_reg <= strap_b;
            strap_aux_reg <= strap_aux;
        end
    end

    // ------------------------------------------------------------
    // Serial interface (mode pin high only)
    // ------------------------------------------------------------
    logic [`CCD_FRAME_W-1:0] rx_reg; // Incoming frame, MSB first
    logic [`CCD_FRAME_W-1:0] tx_reg; // Outgoing copy of the control word
    logic [5:0] bit_cnt_reg; // Bits seen in this frame
    logic serial_on; // Interface usable
    logic frame_done; // Full frame closed
    logic [`CCD_ADDR_W-1:0] frame_addr; // Address nibble
    logic [`CCD_REG_W-1:0] frame_data; // Data field
    logic reg_write; // Write to the control word
    logic store_write; // Save control word into a slot
    logic [`CCD_REG_W-1:0] cfg_reg; // Input and reference control

    assign serial_on = ~strap_default_mode & (state_reg == ST_RUN);
    assign frame_done = serial_on & le_rise & (bit_cnt_reg == 6'(`CCD_FRAME_W));
    assign frame_addr = rx_reg[`CCD_ADDR_W-1:0];
    assign frame_data = rx_reg[`CCD_FRAME_W-1:`CCD_ADDR_W];
    assign reg_write = frame_done & (frame_addr == `CCD_INPUT_AND_REFERENCE_CONTROL_ADDR);
    assign store_write = frame_done & (frame_addr == `CCD_CMD_STORE_ADDR);

    // Shift in on clock rise; a short or long frame is dropped
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rx_reg <= 32'h0000_0000;
            bit_cnt_reg <= 6'h00;
        end else if (!le_low) begin
            bit_cnt_reg <= 6'h00;
        end else if (sclk_rise && serial_on) begin
            rx_reg <= {rx_reg[`CCD_FRAME_W-2:0], sync2_reg[2]};
            if (bit_cnt_reg != 6'h3F) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
        end
    end

    // Every frame returns the control word, shifted out on clock fall
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            tx_reg <= 32'h0000_0000;
            o_spi_miso <= 1'b0;
            o_spi_miso_oe_n <= 1'b1;
        end else begin
            if (le_fall) begin
                tx_reg <= {cfg_reg, 4'h0};
            end else if (sclk_fall && serial_on) begin
                tx_reg <= {tx_reg[`CCD_FRAME_W-2:0], 1'b0};
            end
            o_spi_miso <= tx_reg[`CCD_FRAME_W-1];
            // Pin is the aux strap in default mode, so never driven there
            o_spi_miso_oe_n <= ~(serial_on & le_low);
        end
    end

    // ------------------------------------------------------------
    // Variant store
    // ------------------------------------------------------------
    config_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_rd_en(rd_en),
        .i_rd_addr(variant_idx),
        .o_rd_data(store_rd_data),
        .i_wr_en(store_write),
        .i_wr_addr(frame_data[1:0]),
        .i_wr_data(cfg_reg)
    );

    // ------------------------------------------------------------
    // Working control word
    // ------------------------------------------------------------
    // Loaded from the store after a sample, else written serially
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cfg_reg <= `CCD_INPUT_AND_REFERENCE_CONTROL_RESET;
        end else if (state_reg == ST_FETCH) begin
            cfg_reg <= store_rd_data;
        end else if (reg_write) begin
            cfg_reg <= frame_data;
        end
    end

    // Two-bit field picker, used for several fields
    function automatic logic [1:0] field2(input logic [`CCD_REG_W-1:0] w, input int lo);
        field2 = {w[lo+1], w[lo]};
    endfunction

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [1:0] buf_bits; // {lo, hi} type bits
    logic [1:0] choice_bits; // {bit3, bit2}
    logic osc_sel; // Oscillator path
    logic ctrl_internal; // Bits 2-3 in charge
    buf_type_t buf_type; // Decoded buffer kind
    logic int_primary; // Internal primary code
    logic int_auto; // Internal automatic code
    logic want_primary; // Primary routed
    logic want_secondary; // Secondary routed
    logic want_auto; // Automatic selection on

    assign buf_bits = field2(cfg_reg, `CCD_REF_BUFFER_TYPE_HI_BIT);
    assign choice_bits = field2(cfg_reg, `CCD_REF_INPUT_CHOICE_LO);
    assign osc_sel = cfg_reg[`CCD_OSCILLATOR_PATH_SELECT_BIT];
    assign ctrl_internal = cfg_reg[`CCD_REF_CONTROL_SOURCE_BIT];

    // X=bit0, Y=bit1: 10 PECL, 11 LVDS, else single-ended CMOS
    assign buf_type = (buf_bits == 2'b11) ? BUF_LVDS :
                      (buf_bits == 2'b01) ? BUF_PECL : BUF_CMOS;

    // Bit2=1,bit3=0 primary; both set automatic; others none
    assign int_primary = (choice_bits == 2'b01);
    assign int_auto = (choice_bits == 2'b11);

    // Oscillator path wins over any reference route
    assign want_primary = ~osc_sel & (ctrl_internal ? int_primary : ext_primary);
    assign want_secondary = ~osc_sel & ~ctrl_internal & ~ext_primary;
    assign want_auto = ~osc_sel & ctrl_internal & int_auto;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_ref_buffer_type <= BUF_CMOS;
            o_ref_single_ended <= 1'b1;
            o_route_primary <= 1'b0;
            o_route_secondary <= 1'b0;
            o_auto_select <= 1'b0;
            o_secondary_buffer_off <= 1'b1;
            o_oscillator_path_select <= 1'b0;
            o_detector_pulse_width <= 2'h0;
            o_pump_polarity <= 1'b0;
            o_pump_source_test <= 1'b0;
            o_swap_output_pairs <= 1'b0;
            o_alt_output_type <= 1'b0;
            o_aux_mux_select <= 1'b0;
            o_default_mode_active <= 1'b0;
            o_load_busy <= 1'b1;
        end else begin
            o_ref_buffer_type <= buf_type;
            o_ref_single_ended <= (buf_type == BUF_CMOS);
            o_route_primary <= want_primary;
            o_route_secondary <= want_secondary;
            o_auto_select <= want_auto;
            // Secondary buffer only powered when it may be used
            o_secondary_buffer_off <= ~(want_secondary | want_auto);
            o_oscillator_path_select <= osc_sel;
            o_detector_pulse_width <= field2(cfg_reg, `CCD_DETECTOR_PULSE_WIDTH_LO);
            o_pump_polarity <= cfg_reg[`CCD_PUMP_POLARITY_BIT];
            o_pump_source_test <= cfg_reg[`CCD_PUMP_SOURCE_TEST_BIT];
            o_swap_output_pairs <= strap_a_reg;
            o_alt_output_type <= strap_b_reg;
            o_aux_mux_select <= strap_aux_reg;
            o_default_mode_active <= strap_default_mode;
            o_load_busy <= (state_reg != ST_RUN);
        end
    end

endmodule
`default_nettype wire

// ===== bench/clock_config_default_mode_properties.sv
// Concurrent checks on the loader's ports
`timescale 1ns/1ps
`default_nettype none
module ccd_checker
    import clock_config_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_strap_default_mode_n,
    input wire logic i_power_down_n,
    input wire logic o_spi_miso_oe_n,
    input wire buf_type_t o_ref_buffer_type,
    input wire logic o_ref_single_ended,
    input wire logic o_route_primary,
    input wire logic o_route_secondary,
    input wire logic o_auto_select,
    input wire logic o_secondary_buffer_off,
    input wire logic o_oscillator_path_select,
    input wire logic o_swap_output_pairs,
    input wire logic o_alt_output_type,
    input wire logic o_aux_mux_select,
    input wire logic o_default_mode_active,
    input wire logic o_load_busy
);
    // ------
    // Clocking and load sequences
    // ------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Loader idle long enough for the latches to have landed
    sequence s_settled;
        !o_load_busy [*3];
    endsequence
    // A load that must finish in a bounded time
    sequence s_reload;
        o_load_busy ##[1:10] !o_load_busy;
    endsequence

    // ------
    // Properties
    // ------
    a_cmos_single_ended: assert property (o_ref_single_ended == (o_ref_buffer_type == BUF_CMOS))
        else $error("single-ended flag disagrees with buffer type");
    a_osc_overrides: assert property (o_oscillator_path_select |-> !o_route_primary && !o_route_secondary && !o_auto_select)
        else $error("reference routed while oscillator path chosen");
    a_sec_buffer_off: assert property (o_secondary_buffer_off == !(o_route_secondary || o_auto_select))
        else $error("secondary buffer power disagrees with routing");
    a_single_route: assert property (!(o_route_primary && o_route_secondary))
        else $error("both references routed");
    a_straps_held: assert property (s_settled |-> $stable({o_swap_output_pairs, o_alt_output_type, o_aux_mux_select}))
        else $error("strap latches moved outside a load");
    a_mode_follows: assert property ($fell(i_strap_default_mode_n) |-> ##[1:5] o_default_mode_active)
        else $error("default mode not entered");
    a_oe_serial_only: assert property (!o_spi_miso_oe_n |-> !o_default_mode_active)
        else $error("data out driven in default mode");
    a_pd_reload: assert property ($rose(i_power_down_n) |-> ##[3:12] !o_load_busy)
        else $error("load after power-down exit too slow");
    a_reset_load: assert property ($rose(i_rst_n) |-> s_reload)
        else $error("load after reset did not complete");
    a_serial_no_straps: assert property (!o_default_mode_active [*4] |-> !o_aux_mux_select && !o_swap_output_pairs && !o_alt_output_type)
        else $error("strap flags set in serial mode");
endmodule
bind clock_config_default_mode ccd_checker i_ccd_checker (.i_clk_sys, .i_rst_n,
    .i_strap_default_mode_n, .i_power_down_n, .o_spi_miso_oe_n, .o_ref_buffer_type,
    .o_ref_single_ended, .o_route_primary, .o_route_secondary, .o_auto_select,
    .o_secondary_buffer_off, .o_oscillator_path_select, .o_swap_output_pairs,
    .o_alt_output_type, .o_aux_mux_select, .o_default_mode_active, .o_load_busy);
`default_nettype wire

// ===== bench/strap_host.sv
// Serial configuration host and strap pins facing the loader
`timescale 1ns/1ps
`default_nettype none
module strap_host (
    input wire logic i_clk_sys,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_mosi,
    output logic o_le,
    output logic o_aux
);
    logic [31:0] rd_frame; // Bits read back during the last frame

    // Idle: frame closed, clock parked low
    initial begin
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_le = 1'b1;
        o_aux = 1'b0;
    end

    // ------
    // One 32-bit frame, MSB first, slow clock for the pin synchronisers
    // ------
    task automatic send(input logic [10:0] w, input logic [3:0] addr);
        logic [31:0] f;
        f = {17'h0_0000, w, addr};
        @(posedge i_clk_sys) o_le <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            @(posedge i_clk_sys) o_mosi <= f[i];
            repeat (4) @(posedge i_clk_sys);
            rd_frame <= {rd_frame[30:0], i_miso};
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk_sys);
        o_le <= 1'b1;
        // Stale data line shows the inverse, never the last bit
        o_mosi <= ~f[0];
        repeat (2) @(posedge i_clk_sys);
    endtask

    // ------
    // Static straps for default mode
    // ------
    task automatic strap(input logic a, input logic b, input logic aux);
        @(posedge i_clk_sys);
        o_mosi <= a;
        o_sclk <= b;
        o_le <= 1'b0;
        o_aux <= aux;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the strap-default configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clock_config_pkg::*;
    // ------
    // Pins, observed outputs, counters
    // ------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_n = 1'b1; // Serial mode first
    logic pd_n = 1'b1;
    logic rs = 1'b1;
    wire logic sclk, mosi, le, aux, se, rp, rsec, au, sbo, osc, pp, pst, sw, alt, ax, dm, busy;
    wire logic [1:0] pw;
    wire buf_type_t bt;
    wire logic so; // Serial data out
    wire logic [11:0] obs = {pst, pp, pw, osc, au, rsec, rp, sbo, se, bt};
    wire logic [31:0] rb = i_strap_host.rd_frame; // Last frame read back
    logic [10:0] prev = 11'h000; // Word the next frame reads back
    wire logic [3:0] flg = {sw, alt, ax, dm};
    int errors = 0;
    int n_checks = 0;
    logic [10:0] words [10] = '{11'h000, 11'h001, 11'h023, 11'h027, 11'h02C,
                               11'h018, 11'h040, 11'h080, 11'h0C2, 11'h600};

    always #5 clk = ~clk;

    strap_host i_strap_host (.i_clk_sys(clk), .i_miso(so), .o_sclk(sclk), .o_mosi(mosi), .o_le(le),
        .o_aux(aux));
    clock_config_default_mode i_clock_config_default_mode (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_strap_default_mode_n(mode_n), .i_spi_clk_pin(sclk), .i_spi_mosi_pin(mosi),
        .i_spi_le_pin(le), .i_spi_miso_pin(aux), .o_spi_miso(so), .o_spi_miso_oe_n(),
        .i_ref_select(rs), .i_power_down_n(pd_n), .o_ref_buffer_type(bt),
        .o_ref_single_ended(se), .o_route_primary(rp), .o_route_secondary(rsec),
        .o_auto_select(au), .o_secondary_buffer_off(sbo), .o_oscillator_path_select(osc),
        .o_detector_pulse_width(pw), .o_pump_polarity(pp), .o_pump_source_test(pst),
        .o_swap_output_pairs(sw), .o_alt_output_type(alt), .o_aux_mux_select(ax),
        .o_default_mode_active(dm), .o_load_busy(busy));

    // Expected outputs from a control word and the select pin
    function automatic logic [11:0] expect_out(input logic [10:0] w, input logic pin);
        logic [1:0] b;
        logic pri, sec, aut;
        b = (w[1:0] == 2'b01) ? BUF_PECL : (w[1:0] == 2'b11) ? BUF_LVDS : BUF_CMOS;
        pri = !w[4] && (w[5] ? (w[2] && !w[3]) : pin);
        sec = !w[4] && !w[5] && !pin;
        aut = !w[4] && w[5] && w[2] && w[3];
        return {w[10], w[9], w[7:6], w[4], aut, sec, pri, !(sec || aut), b == BUF_CMOS, b};
    endfunction

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Power-down pulse, then time for the strap load
    task automatic pulse_pd();
        @(posedge clk) pd_n <= 1'b0;
        repeat (5) @(posedge clk);
        pd_n <= 1'b1;
        repeat (25) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard, well beyond the roughly 4400 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        check("power-up word", expect_out(11'h000, 1'b1), obs);
        check("serial flags", 12'h000, {8'h00, flg});
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            rs <= i[0];
            i_strap_host.send(words[i], 4'h0);
            check("readback", {1'b0, prev}, {(|rb[31:15]) | (|rb[3:0]), rb[14:4]});
            prev = words[i];
            repeat (12) @(posedge clk);
            check("control word", expect_out(words[i], i[0]), obs);
        end
        $display("test control word done");
        // Distinct words in store slots 3 and 1
        i_strap_host.send(11'h0C1, 4'h0);
        i_strap_host.send(11'h003, 4'hF);
        i_strap_host.send(11'h201, 4'h0);
        i_strap_host.send(11'h001, 4'hF);
        mode_n <= 1'b0;
        repeat (10) @(posedge clk);
        i_strap_host.strap(1'b1, 1'b1, 1'b1);
        pulse_pd();
        check("variant 3 word", expect_out(11'h0C1, rs), obs);
        check("variant 3 flags", 12'h00F, {8'h00, flg});
        i_strap_host.strap(1'b1, 1'b0, 1'b0);
        repeat (20) @(posedge clk);
        check("straps ignored", 12'h00F, {8'h00, flg});
        pulse_pd();
        check("variant 1 word", expect_out(11'h201, rs), obs);
        check("variant 1 flags", 12'h009, {8'h00, flg});
        $display("test default mode done");
        complete_run();
    end
endmodule
`default_nettype wire
